// ### logic/sgp_gpio_port.sv
// Purpose: gpio port with peripheral sharing and change notification
// Assumes: classic wishbone slave, 32-bit data, one clock at 50 MHz
// Notes:   pins are split into in/out/oe; the bench resolves the wire
//
// How it works
// R1: a peripheral driving a shared pin owns its output data and enable
// R2: an actively driving peripheral disables the port driver; pin still readable
// R3: an enabled but idle peripheral lets the port drive the pin
// R4: the port's driven output never feeds a sharing peripheral's input
// R5: direction bit 1 makes the pin an input, 0 an output
// R6: reset makes every pin an input
// R7: latch reads return latch contents; latch writes update the latch
// R8: pin-level reads return pins; pin-level writes update the latch
// R9: unimplemented bits are disabled and read zero in latch, direction, pin
// R10: pins shared only with input functions behave as dedicated port pins
// R11: open-drain bit makes the pin drive low only and release high; a pin owned by a driving peripheral still drives both levels
// R12: analog-configured pins read as zero from the pin-level register
// R13: software sets direction to input before analog use of a pin
// R14: software waits one instruction between port write and port read
// R15: any enabled change-notify input changing raises an interrupt request
// R16: change detection keeps running in sleep so a change can wake
// R17: two enable registers select which change inputs interrupt
// R18: two pull-up registers switch on weak pull-ups per change input
// R19: software disables pull-ups on pins used as digital outputs
// R20: pin inputs pass synchronising flip-flops before reads or detection
// R21: change flag is sticky until software clears; compare with last sample
`include "sgp_consts.svh"

module sgp_gpio_port (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [`SGP_ADDR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // pins
  input  wire logic [`SGP_PORT_W-1:0]   pinIn,
  output logic      [`SGP_PORT_W-1:0]   pinOut,
  output logic      [`SGP_PORT_W-1:0]   pinOe,
  // sharing peripherals
  input  wire logic [`SGP_PORT_W-1:0]   periphEn,
  input  wire logic [`SGP_PORT_W-1:0]   periphDrive,
  input  wire logic [`SGP_PORT_W-1:0]   periphOut,
  output logic      [`SGP_PORT_W-1:0]   periphIn,
  // change notification
  input  wire logic [`SGP_CN_W-1:0]     changeNotifyIn,
  output logic      [`SGP_CN_W-1:0]     pullupEn,
  output logic                          changeIrq
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge for the 16-bit registers
  function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction

  function automatic logic [31:0] zext16(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // input synchronisers

  sgp_pkg::sgp_port_t pinSync;
  sgp_pkg::sgp_cn_t   cnSync;

  sgp_sync #(.W(`SGP_PORT_W)) uPinSync ( // R20
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  );

  sgp_sync #(.W(`SGP_CN_W)) uCnSync ( // R20
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (changeNotifyIn),
    .syncOut (cnSync)
  );

  ////////////////////////////////////////////////////////////////////
  // bus handshake

  sgp_pkg::sgp_bus_t busState_q, busState_d;
  logic [31:0]       datOut_q, datOut_d;
  logic              ackNow;
  logic              wrNow;
  logic [31:0]       readMux;

  // ack one cycle after the request; write lands on the ack edge
  assign ackNow = wb_cyc_i && wb_stb_i && (busState_q == sgp_pkg::SGP_BUS_IDLE);
  assign wrNow  = wb_cyc_i && wb_stb_i && wb_we_i && (busState_q == sgp_pkg::SGP_BUS_ACK);

  always_comb begin
    busState_d = sgp_pkg::SGP_BUS_IDLE;
    datOut_d   = datOut_q;
    case (busState_q)
      sgp_pkg::SGP_BUS_IDLE: begin
        if (ackNow) begin
          busState_d = sgp_pkg::SGP_BUS_ACK;
          datOut_d   = wb_we_i ? 32'h0000_0000 : readMux;
        end
      end
      sgp_pkg::SGP_BUS_ACK: begin
        busState_d = sgp_pkg::SGP_BUS_IDLE;
      end
      default: begin
        busState_d = sgp_pkg::SGP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busState_q <= sgp_pkg::SGP_BUS_IDLE;
      datOut_q   <= 32'h0000_0000;
    end else begin
      busState_q <= busState_d;
      datOut_q   <= datOut_d;
    end
  end

  assign wb_ack_o = (busState_q == sgp_pkg::SGP_BUS_ACK);
  assign wb_dat_o = datOut_q;

  ////////////////////////////////////////////////////////////////////
  // port registers

  sgp_pkg::sgp_port_t dir_q, dir_d;
  sgp_pkg::sgp_port_t lat_q, lat_d;
  sgp_pkg::sgp_port_t odc_q, odc_d;
  sgp_pkg::sgp_port_t analog_q, analog_d;
  logic [15:0]        cnEnLo_q, cnEnLo_d;
  logic [`SGP_CN_HI_W-1:0] cnEnHi_q, cnEnHi_d;
  logic [15:0]        cnPuLo_q, cnPuLo_d;
  logic [`SGP_CN_HI_W-1:0] cnPuHi_q, cnPuHi_d;
  logic [15:0]        mHi;

  always_comb begin
    dir_d    = dir_q;
    lat_d    = lat_q;
    odc_d    = odc_q;
    analog_d = analog_q;
    cnEnLo_d = cnEnLo_q;
    cnEnHi_d = cnEnHi_q;
    cnPuLo_d = cnPuLo_q;
    cnPuHi_d = cnPuHi_q;
    mHi      = 16'h0000;
    if (wrNow) begin
      case (wb_adr_i)
        `SGP_OFF_DIR:     dir_d    = laneMerge(dir_q, wb_dat_i, wb_sel_i) | ~`SGP_IMPL_MASK;
        `SGP_OFF_LAT:     lat_d    = laneMerge(lat_q, wb_dat_i, wb_sel_i); // R7
        `SGP_OFF_PIN:     lat_d    = laneMerge(lat_q, wb_dat_i, wb_sel_i); // R8
        `SGP_OFF_ODC:     odc_d    = laneMerge(odc_q, wb_dat_i, wb_sel_i); // R11
        `SGP_OFF_ANALOG:  analog_d = laneMerge(analog_q, wb_dat_i, wb_sel_i);
        `SGP_OFF_CNEN_LO: cnEnLo_d = laneMerge(cnEnLo_q, wb_dat_i, wb_sel_i); // R17
        `SGP_OFF_CNEN_HI: begin
          mHi      = laneMerge({11'h000, cnEnHi_q}, wb_dat_i, wb_sel_i);
          cnEnHi_d = mHi[`SGP_CN_HI_W-1:0]; // R17
        end
        `SGP_OFF_CNPU_LO: cnPuLo_d = laneMerge(cnPuLo_q, wb_dat_i, wb_sel_i); // R18
        `SGP_OFF_CNPU_HI: begin
          mHi      = laneMerge({11'h000, cnPuHi_q}, wb_dat_i, wb_sel_i);
          cnPuHi_d = mHi[`SGP_CN_HI_W-1:0]; // R18
        end
        default: begin
        end
      endcase
    end
    // unimplemented latch lanes hold no state
    lat_d = lat_d & `SGP_IMPL_MASK; // R9
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dir_q    <= `SGP_RST_DIR; // R6
      lat_q    <= `SGP_RST_ZERO16;
      odc_q    <= `SGP_RST_ZERO16;
      analog_q <= `SGP_RST_ZERO16;
      cnEnLo_q <= `SGP_RST_ZERO16;
      cnEnHi_q <= `SGP_RST_ZERO5;
      cnPuLo_q <= `SGP_RST_ZERO16;
      cnPuHi_q <= `SGP_RST_ZERO5;
    end else begin
      dir_q    <= dir_d;
      lat_q    <= lat_d;
      odc_q    <= odc_d;
      analog_q <= analog_d;
      cnEnLo_q <= cnEnLo_d;
      cnEnHi_q <= cnEnHi_d;
      cnPuLo_q <= cnPuLo_d;
      cnPuHi_q <= cnPuHi_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // change notification

  sgp_pkg::sgp_cn_t cnPrev_q, cnPrev_d;
  sgp_pkg::sgp_cn_t cnEnable;
  logic             cnFlag_q, cnFlag_d;
  logic             cnClear;
  logic             cnHit;
  logic [2:0]       settle_q, settle_d;

  assign cnEnable = {cnEnHi_q, cnEnLo_q};
  assign cnClear  = wrNow && (wb_adr_i == `SGP_OFF_CNSTAT) && wb_sel_i[0]
                    && wb_dat_i[`SGP_CNSTAT_FLAG_BIT];

  // detection is never gated by a sleep or idle state
  always_comb begin
    cnPrev_d = cnSync;
    settle_d = (settle_q == `SGP_SYNC_SETTLE) ? settle_q : settle_q + 3'h1;
    // synchronisers clear to 0 on reset; a high pin would look like a change
    cnHit    = (settle_q == `SGP_SYNC_SETTLE)
               && (|((cnSync ^ cnPrev_q) & cnEnable)); // R15 R16 R21
    // a change in the clearing cycle wins over the clear
    cnFlag_d = (cnFlag_q & ~cnClear) | cnHit; // R21
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnPrev_q <= `SGP_RST_ZERO21;
      cnFlag_q <= 1'b0;
      settle_q <= 3'h0;
    end else begin
      cnPrev_q <= cnPrev_d;
      cnFlag_q <= cnFlag_d;
      settle_q <= settle_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    case (wb_adr_i)
      `SGP_OFF_DIR:     readMux = zext16(dir_q & `SGP_IMPL_MASK); // R9
      `SGP_OFF_LAT:     readMux = zext16(lat_q); // R7
      `SGP_OFF_PIN:     readMux = zext16(pinSync & ~analog_q & `SGP_IMPL_MASK); // R8 R12 R9
      `SGP_OFF_ODC:     readMux = zext16(odc_q);
      `SGP_OFF_ANALOG:  readMux = zext16(analog_q);
      `SGP_OFF_CNEN_LO: readMux = zext16(cnEnLo_q);
      `SGP_OFF_CNEN_HI: readMux = {27'h0000000, cnEnHi_q};
      `SGP_OFF_CNPU_LO: readMux = zext16(cnPuLo_q);
      `SGP_OFF_CNPU_HI: readMux = {27'h0000000, cnPuHi_q};
      `SGP_OFF_CNSTAT:  readMux = {31'h00000000, cnFlag_q};
      default:          readMux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // pin ownership and registered pin drive

  sgp_pkg::sgp_port_t muxOut, muxOe, muxPin;
  sgp_pkg::sgp_port_t pinOut_q, pinOe_q, periphIn_q;
  sgp_pkg::sgp_cn_t   pullup_q;
  logic               irq_q;

  sgp_pin_mux uMux (
    .dir         (dir_q),
    .lat         (lat_q),
    .odc         (odc_q),
    .periphEn    (periphEn),
    .periphDrive (periphDrive),
    .periphOut   (periphOut),
    .pinLevel    (pinSync),
    .pinOut      (muxOut),
    .pinOe       (muxOe),
    .periphIn    (muxPin)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinOut_q   <= `SGP_RST_ZERO16;
      pinOe_q    <= `SGP_RST_ZERO16;
      periphIn_q <= `SGP_RST_ZERO16;
      pullup_q   <= `SGP_RST_ZERO21;
      irq_q      <= 1'b0;
    end else begin
      pinOut_q   <= muxOut; // R1
      pinOe_q    <= muxOe; // R2 R3 R5
      periphIn_q <= muxPin; // R4
      pullup_q   <= {cnPuHi_q, cnPuLo_q}; // R18
      irq_q      <= cnFlag_d; // R15
    end
  end

  assign pinOut    = pinOut_q;
  assign pinOe     = pinOe_q;
  assign periphIn  = periphIn_q;
  assign pullupEn  = pullup_q;
  assign changeIrq = irq_q;

endmodule

// ### logic/sgp_consts.svh
// Purpose: constants for the shared gpio port with change notify
// Assumes: 32-bit classic wishbone, registers one per aligned word
// Notes:   port data sits in the low bits, upper bits read as zero
`ifndef SGP_CONSTS_SVH
`define SGP_CONSTS_SVH

`define SGP_PORT_W      16
`define SGP_CN_W        21
`define SGP_CN_HI_W     5
`define SGP_ADDR_W      8

`define SGP_OFF_DIR     8'h00
`define SGP_OFF_LAT     8'h04
`define SGP_OFF_PIN     8'h08
`define SGP_OFF_ODC     8'h0c
`define SGP_OFF_CNEN_LO 8'h10
`define SGP_OFF_CNEN_HI 8'h14
`define SGP_OFF_CNPU_LO 8'h18
`define SGP_OFF_CNPU_HI 8'h1c
`define SGP_OFF_ANALOG  8'h20
`define SGP_OFF_CNSTAT  8'h24

`define SGP_CNSTAT_FLAG_BIT 0

`define SGP_RST_DIR     16'hffff
`define SGP_RST_ZERO16  16'h0000
`define SGP_RST_ZERO21  21'h0
`define SGP_RST_ZERO5   5'h00
`define SGP_SYNC_SETTLE 3'h5
`define SGP_IMPL_MASK   16'h3fff

`endif

// ### logic/sgp_pkg.sv
// Purpose: shared types of the gpio port
// Assumes: sgp_consts.svh gives the widths
// Notes:   holds types only
`include "sgp_consts.svh"

package sgp_pkg;
  typedef logic [`SGP_PORT_W-1:0] sgp_port_t;
  typedef logic [`SGP_CN_W-1:0]   sgp_cn_t;
  typedef enum logic [0:0] {
    SGP_BUS_IDLE = 1'b0,
    SGP_BUS_ACK  = 1'b1
  } sgp_bus_t;
endpackage

// ### logic/sgp_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes:   the output moves only when stages two and three agree
module sgp_sync #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= asyncIn;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;
endmodule

// ### logic/sgp_pin_mux.sv
// Purpose: per-pin ownership mux between port and peripheral
// Assumes: all inputs are on clk; result is registered by the caller
// Notes:   combinational only
`include "sgp_consts.svh"

module sgp_pin_mux (
  input  wire logic [`SGP_PORT_W-1:0] dir,
  input  wire logic [`SGP_PORT_W-1:0] lat,
  input  wire logic [`SGP_PORT_W-1:0] odc,
  input  wire logic [`SGP_PORT_W-1:0] periphEn,
  input  wire logic [`SGP_PORT_W-1:0] periphDrive,
  input  wire logic [`SGP_PORT_W-1:0] periphOut,
  input  wire logic [`SGP_PORT_W-1:0] pinLevel,
  output logic      [`SGP_PORT_W-1:0] pinOut,
  output logic      [`SGP_PORT_W-1:0] pinOe,
  output logic      [`SGP_PORT_W-1:0] periphIn
);
  logic [`SGP_PORT_W-1:0] periphOwns;
  logic [`SGP_PORT_W-1:0] portDrives;

  always_comb begin
    // an input-only peripheral never raises periphDrive, so the port keeps the pin
    periphOwns = periphEn & periphDrive & `SGP_IMPL_MASK; // R1 R2 R3 R10 R9
    // open drain: drive only a low, release for a high
    portDrives = ~dir & ~(odc & lat) & `SGP_IMPL_MASK; // R5 R11 R9
    // ownership is chosen bit by bit, never for the whole port at once
    pinOut     = (periphOwns & periphOut) | (~periphOwns & ~odc & lat); // R1 R11
    pinOe      = (periphOwns & periphEn) | (~periphOwns & portDrives); // R2 R3
    // the port's own driven level never loops into a peripheral input
    periphIn   = pinLevel & ~(~periphOwns & portDrives); // R4
  end
endmodule

// ### sim/sgp_gpio_port_asserts.sv
// Purpose: protocol and pin checks on the gpio port
// Assumes: sees top-level ports only
// Notes:   the irq may drop one or two edges after the clearing write
`include "sgp_consts.svh"
module sgp_gpio_port_asserts (
  input logic        clk,
  input logic        resetn,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [7:0]  wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic        wb_ack_o,
  input logic [15:0] pinOut,
  input logic [15:0] pinOe,
  input logic [15:0] periphEn,
  input logic [15:0] periphDrive,
  input logic [15:0] periphOut,
  input logic [15:0] periphIn,
  input logic [20:0] changeNotifyIn,
  input logic        changeIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [20:0] cnPrev_q;
  logic [20:0] cnPrev_d;
  logic [3:0]  since_q;
  logic [3:0]  since_d;
  wire  [15:0] own = periphEn & periphDrive & `SGP_IMPL_MASK;
  wire         clrHit = wb_ack_o & wb_we_i & wb_cyc_i & wb_stb_i & wb_dat_i[0]
                        & (wb_adr_i == `SGP_OFF_CNSTAT);
  // cycles since any change input last moved, saturating
  always_comb begin
    cnPrev_d = changeNotifyIn;
    since_d = (since_q == 4'hf) ? since_q : since_q + 4'h1;
    if (changeNotifyIn != cnPrev_q) since_d = 4'h0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnPrev_q <= '0;
      since_q <= 4'hf;
    end else begin
      cnPrev_q <= cnPrev_d;
      since_q <= since_d;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_unimpl_off: assert property (pinOe[15:14] == 2'h0)
    else $error("unimplemented pin driven");
  chk_periph_oe: assert property ($past(resetn) |-> (pinOe & $past(own)) == $past(own))
    else $error("driving peripheral lost its enable");
  chk_periph_dat: assert property ($past(resetn) |->
    ((pinOut ^ $past(periphOut)) & $past(own)) == 16'h0)
    else $error("pin value not taken from peripheral");
  chk_no_loop: assert property ((periphIn & pinOe & $past(pinOe) & ~$past(own)
    & ~$past(own, 2)) == 16'h0)
    else $error("port output fed to peripheral input");
  chk_irq_clear: assert property ($fell(changeIrq) |-> $past(clrHit) || $past(clrHit, 2))
    else $error("change irq dropped without a clear");
  chk_irq_cause: assert property ($rose(changeIrq) |-> since_q < 4'ha)
    else $error("change irq without an input change");
  cov_irq: cover property ($rose(changeIrq));
  cov_own: cover property (|own);
  cov_clear: cover property (clrHit);
endmodule

bind sgp_gpio_port sgp_gpio_port_asserts u_chk (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .pinOut, .pinOe, .periphEn, .periphDrive,
  .periphOut, .periphIn, .changeNotifyIn, .changeIrq);

// ### sim/sgp_pin_model.sv
// Purpose: outside pin network facing the gpio port
// Assumes: extLevel stands for outside drivers and pull-ups
// Notes:   a released line never keeps the port's last value
module sgp_pin_model (
  input  logic [15:0] pinOut,
  input  logic [15:0] pinOe,
  input  logic [15:0] extLevel,
  output logic [15:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // released open-drain lines are lifted by the outside level
  assign pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// ### sim/tb.sv
// Purpose: self-checking bench for the shared gpio port
// Assumes: 50 MHz clock, ack one cycle after a request
// Notes:   ack waits are bounded only by the cycle ceiling
`include "sgp_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, changeIrq;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] pinIn, pinOut, pinOe, periphEn, periphDrive, periphOut, periphIn, ext;
  logic [20:0] changeNotifyIn, pullupEn;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  sgp_gpio_port dut (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .pinIn, .pinOut, .pinOe, .periphEn, .periphDrive,
    .periphOut, .periphIn, .changeNotifyIn, .pullupEn, .changeIrq);
  sgp_pin_model pins (.pinOut, .pinOe, .extLevel(ext), .pinLevel(pinIn));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'h3;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(32'(pinOe), 32'h0);
    rdchk(`SGP_OFF_DIR, 32'h3fff);
    rdchk(`SGP_OFF_LAT, 32'h0);
    rdchk(8'h30, 32'h0);
  endtask
  task automatic t_port;
    wb(1'b1, `SGP_OFF_DIR, 32'h00ff);
    wb(1'b1, `SGP_OFF_LAT, 32'hffff);
    wb(1'b1, `SGP_OFF_PIN, 32'h0);
    idle(6);
    chk(32'(pinOe), 32'h3f00);
    chk(32'(pinOut & pinOe), 32'h0);
    rdchk(`SGP_OFF_LAT, 32'h0);
    rdchk(`SGP_OFF_PIN, 32'h00ff);
    wb(1'b1, `SGP_OFF_LAT, 32'hffff);
    rdchk(`SGP_OFF_LAT, 32'h3fff);
    idle(2);
    chk(32'(pinOut & pinOe), 32'h3f00);
  endtask
  task automatic t_od;
    ext <= 16'hffff;
    wb(1'b1, `SGP_OFF_ODC, 32'h3f00);
    wb(1'b1, `SGP_OFF_LAT, 32'h0f00);
    idle(6);
    chk(32'(pinOe), 32'h3000);
    chk(32'(pinOut & pinOe), 32'h0);
    rdchk(`SGP_OFF_PIN, 32'h0fff);
    // low pins stay inputs before analog use
    wb(1'b1, `SGP_OFF_ANALOG, 32'h000f);
    idle(6);
    rdchk(`SGP_OFF_PIN, 32'h0ff0);
    wb(1'b1, `SGP_OFF_ANALOG, 32'h0);
    wb(1'b1, `SGP_OFF_ODC, 32'h0);
  endtask
  task automatic t_periph;
    wb(1'b1, `SGP_OFF_DIR, 32'h00fc);
    wb(1'b1, `SGP_OFF_LAT, 32'h0f02);
    periphEn <= 16'h0007;
    periphDrive <= 16'h0001;
    periphOut <= 16'h0005;
    idle(6);
    chk(32'(pinOe & 16'h0007), 32'h3);
    chk(32'(pinOut & 16'h0007), 32'h3);
    chk(32'(periphIn & 16'h0002), 32'h0);
    chk(32'(periphIn & 16'h0004), 32'h4);
    rdchk(`SGP_OFF_PIN, 32'h0fff);
    periphDrive <= 16'h0;
    idle(3);
    chk(32'(pinOut & 16'h0001), 32'h0);
    chk(32'(pinOe & 16'h0001), 32'h1);
    periphEn <= 16'h0;
  endtask
  task automatic t_cn;
    wb(1'b1, `SGP_OFF_CNEN_LO, 32'h0001);
    wb(1'b1, `SGP_OFF_CNEN_HI, 32'h0010);
    // change pins are inputs here, so pull-ups may stay on
    wb(1'b1, `SGP_OFF_CNPU_LO, 32'h8001);
    wb(1'b1, `SGP_OFF_CNPU_HI, 32'h0011);
    idle(2);
    chk(32'(pullupEn), 32'h118001);
    changeNotifyIn <= 21'h000002;
    idle(10);
    chk(32'(changeIrq), 32'h0);
    changeNotifyIn <= 21'h100002;
    idle(10);
    chk(32'(changeIrq), 32'h1);
    wb(1'b1, `SGP_OFF_CNSTAT, 32'h1);
    idle(3);
    chk(32'(changeIrq), 32'h0);
    changeNotifyIn <= 21'h100003;
    idle(30);
    chk(32'(changeIrq), 32'h1);
    wb(1'b1, `SGP_OFF_CNSTAT, 32'h1);
    idle(3);
    chk(32'(changeIrq), 32'h0);
  endtask
  initial begin
    resetn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0;
    ext = 16'h00ff;
    periphEn = 16'h0;
    periphDrive = 16'h0;
    periphOut = 16'h0;
    changeNotifyIn = 21'h0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_port();
    t_od();
    t_periph();
    t_cn();
    test_done();
  end
endmodule
